// ---- core/motion_alarm_detector.sv ----
`timescale 1ns/100ps
module motion_alarm_detector #(
   parameter int BLINK_CYCLES = motion_alarm_pkg::BLINK_CYC,
   parameter int PAUSE_CYCLES = motion_alarm_pkg::PAUSE_CYC,
   parameter int SPEED_W = 8,
   parameter int CUR_W = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // sensors
   input wire logic home_sensor_input,
   input wire logic forward_limit_input,
   input wire logic reverse_limit_input,
   input wire logic step_timing_output,
   input wire logic encoder_zero_output,
   input wire logic sensor_input_a,
   input wire logic safe_torque_off_input_a,
   input wire logic safe_torque_off_input_b,
   // homing status
   input wire logic homing_three_sensor,
   input wire logic homing_active,
   input wire logic homing_done,
   input wire logic homing_offset_move,
   input wire logic home_is_set,
   // settings
   input wire logic tim_zsg_check_en,
   input wire logic sensor_input_a_check_en,
   input wire logic [1:0] limit_action,
   input wire logic [1:0] swot_action,
   input wire logic sto_alarm_mode,
   input wire logic wrap_enabled,
   input wire logic push_supported,
   input wire logic gear_out_of_spec,
   // position and operation events
   input wire logic sw_limit_reached,
   input wire logic mech_limit_reached,
   input wire logic op_start,
   input wire logic op_wrap,
   input wire logic op_push,
   input wire logic [SPEED_W-1:0] op_speed,
   input wire logic [CUR_W-1:0] op_current,
   input wire logic [SPEED_W-1:0] speed_limit,
   input wire logic [CUR_W-1:0] current_limit,
   // host clear
   input wire logic alarm_clear_input,
   // status
   output logic alarm_active,
   output logic [7:0] alarm_code,
   output logic motor_current_on,
   output logic indicator_led
);
   import motion_alarm_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ON = 2'b01,
      ST_OFF = 2'b10,
      ST_PAUSE = 2'b11
   } blink_t;

   // =========================================================
   // fault detection
   logic seen_home_ff;
   logic seen_sig_ff;
   wire ls_any = forward_limit_input | reverse_limit_input;
   wire f_no_home = homing_active & homing_three_sensor & ls_any &
      ~seen_home_ff & ~home_sensor_input; // R1
   wire sig_hit = (tim_zsg_check_en &
      (step_timing_output | encoder_zero_output)) |
      (sensor_input_a_check_en & sensor_input_a); // R3
   wire f_sig = homing_done & (tim_zsg_check_en | sensor_input_a_check_en) &
      ~seen_sig_ff & ~sig_hit; // R2
   wire f_hw_ot = ((limit_action == LS_ACT_IMM_ALM) |
      (limit_action == LS_ACT_DEC_ALM)) & ls_any; // R4
   wire f_sw_ot = ((swot_action == SWOT_IMM_ALM) |
      (swot_action == SWOT_DEC_ALM)) & sw_limit_reached; // R5
   wire f_sto = sto_alarm_mode &
      (~safe_torque_off_input_a | ~safe_torque_off_input_b); // R6
   wire f_offset = homing_offset_move & ls_any; // R7
   wire f_mech = home_is_set & mech_limit_reached; // R8
   wire f_op = op_start & ((op_speed == SPEED_ZERO[SPEED_W-1:0]) | // R9
      (op_wrap & ~wrap_enabled) | // R10
      (op_speed > speed_limit) | (op_current > current_limit) | // R11
      (op_push & ~push_supported)); // R12
   wire f_gear = gear_out_of_spec; // R13

   // priority: non-clearable first, then current-cutting, then the rest
   wire any_fault = f_gear | f_sto | f_op | f_mech | f_offset | f_sw_ot |
      f_hw_ot | f_sig | f_no_home;
   wire [7:0] new_code =
      f_gear ? CODE_GEAR :
      f_sto ? CODE_STO :
      f_offset ? CODE_OFFSET :
      f_hw_ot ? CODE_HW_OT :
      f_sw_ot ? CODE_SW_OT :
      f_mech ? CODE_MECH_OT :
      f_op ? CODE_OPDATA :
      f_sig ? CODE_SIG : CODE_NO_HOME;

   function automatic logic cuts_current(input logic [7:0] c);
      cuts_current = (c == CODE_STO) | (c == CODE_GEAR);
   endfunction : cuts_current

   function automatic logic [3:0] blinks_of(input logic [7:0] c);
      blinks_of = (c == CODE_STO) ? BLINK_ONE : BLINK_SEVEN;
   endfunction : blinks_of

   // =========================================================
   // homing trackers
   always_ff @(posedge clk_sys) begin
      if (!rstn || !homing_active) begin
         seen_home_ff <= 1'b0;
      end else if (home_sensor_input) begin
         seen_home_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn || !homing_active) begin
         seen_sig_ff <= 1'b0;
      end else if (sig_hit) begin
         seen_sig_ff <= 1'b1;
      end
   end

   // =========================================================
   // alarm latch
   logic active_ff;
   logic [7:0] code_ff;
   wire clear_ok = alarm_clear_input & active_ff & (code_ff != CODE_GEAR);
   wire take = any_fault & (~active_ff | clear_ok); // first alarm stays
   wire nxt_active = take | (active_ff & ~clear_ok);
   wire [7:0] nxt_code = take ? new_code : (clear_ok ? CODE_NONE : code_ff);

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         active_ff <= 1'b0;
         code_ff <= CODE_NONE;
      end else begin
         active_ff <= nxt_active; // R16
         code_ff <= nxt_code; // R16
      end
   end

   logic cur_ff;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cur_ff <= 1'b1;
      end else begin
         cur_ff <= ~(nxt_active & cuts_current(nxt_code)); // R14 R15
      end
   end

   // =========================================================
   // indicator blinker
   blink_t st_ff;
   logic [31:0] tmr_ff;
   logic [3:0] cnt_ff;
   logic led_ff;
   blink_t nxt_st;
   logic [31:0] nxt_tmr;
   logic [3:0] nxt_cnt;
   wire tmr_done = (tmr_ff == 32'h0);

   always_comb begin
      nxt_st = st_ff;
      nxt_tmr = tmr_done ? 32'h0 : tmr_ff - 32'h1;
      nxt_cnt = cnt_ff;
      if (!active_ff) begin
         nxt_st = ST_IDLE;
         nxt_tmr = 32'h0;
      end else begin
         unique case (st_ff)
            ST_IDLE: begin
               nxt_st = ST_ON;
               nxt_tmr = 32'(BLINK_CYCLES - 1);
               nxt_cnt = blinks_of(code_ff); // R16
            end
            ST_ON: begin
               if (tmr_done) begin
                  nxt_st = ST_OFF;
                  nxt_tmr = 32'(BLINK_CYCLES - 1);
                  nxt_cnt = cnt_ff - 4'h1;
               end
            end
            ST_OFF: begin
               if (tmr_done) begin
                  nxt_st = (cnt_ff == 4'h0) ? ST_PAUSE : ST_ON;
                  nxt_tmr = (cnt_ff == 4'h0) ? 32'(PAUSE_CYCLES - 1) :
                     32'(BLINK_CYCLES - 1);
               end
            end
            ST_PAUSE: begin
               if (tmr_done) begin
                  nxt_st = ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_ff <= ST_IDLE;
         tmr_ff <= 32'h0;
         cnt_ff <= 4'h0;
         led_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         tmr_ff <= nxt_tmr;
         cnt_ff <= nxt_cnt;
         led_ff <= (nxt_st == ST_ON);
      end
   end

   assign alarm_active = active_ff;
   assign alarm_code = code_ff;
   assign motor_current_on = cur_ff;
   assign indicator_led = led_ff;

   // =========================================================
   // checks
   property p_gear_sticky;
      @(posedge clk_sys) disable iff (!rstn)
      (active_ff && code_ff == CODE_GEAR) |=>
         (active_ff && code_ff == CODE_GEAR);
   endproperty
   a_gear_sticky: assert property (p_gear_sticky) // R13
      else $error("gear alarm was cleared");

   property p_sto_cut;
      @(posedge clk_sys) disable iff (!rstn)
      (active_ff && code_ff == CODE_STO) |-> !motor_current_on;
   endproperty
   a_sto_cut: assert property (p_sto_cut) // R6
      else $error("current on during safe-torque-off alarm");

   property p_exc_keep;
      @(posedge clk_sys) disable iff (!rstn)
      (active_ff && !cuts_current(code_ff)) |-> motor_current_on;
   endproperty
   a_exc_keep: assert property (p_exc_keep) // R15
      else $error("current cut on excitation alarm");

   property p_hw_ot;
      @(posedge clk_sys) disable iff (!rstn)
      (!active_ff && f_hw_ot && !f_gear && !f_sto && !f_offset) |=>
         (active_ff && code_ff == CODE_HW_OT);
   endproperty
   a_hw_ot: assert property (p_hw_ot) // R4
      else $error("limit alarm not raised");

   property p_sw_ot;
      @(posedge clk_sys) disable iff (!rstn)
      (!active_ff && sw_limit_reached && swot_action == SWOT_IMM_ALM) |=>
         active_ff;
   endproperty
   a_sw_ot: assert property (p_sw_ot) // R5
      else $error("software overtravel alarm not raised");

   property p_opdata;
      @(posedge clk_sys) disable iff (!rstn)
      (!active_ff && op_start && op_speed == SPEED_ZERO[SPEED_W-1:0] &&
         !f_gear && !f_sto && !f_offset && !f_hw_ot && !f_sw_ot && !f_mech)
         |=> (code_ff == CODE_OPDATA);
   endproperty
   a_opdata: assert property (p_opdata) // R9
      else $error("zero speed start not flagged");

   property p_clear;
      @(posedge clk_sys) disable iff (!rstn)
      (active_ff && code_ff != CODE_GEAR && alarm_clear_input && !any_fault)
         |=> !active_ff;
   endproperty
   a_clear: assert property (p_clear) // R1
      else $error("clearable alarm not cleared");

   property p_led_quiet;
      @(posedge clk_sys) disable iff (!rstn)
      !active_ff ##1 !active_ff |-> !indicator_led;
   endproperty
   a_led_quiet: assert property (p_led_quiet) // R16
      else $error("indicator lit without alarm");

   property p_offset;
      @(posedge clk_sys) disable iff (!rstn)
      (!active_ff && homing_offset_move && forward_limit_input &&
         !f_gear && !f_sto) |=> (code_ff == CODE_OFFSET);
   endproperty
   a_offset: assert property (p_offset) // R7
      else $error("offset limit alarm missing");

   property p_sto_raise;
      @(posedge clk_sys) disable iff (!rstn)
      (!active_ff && sto_alarm_mode && !safe_torque_off_input_b && !f_gear)
         |=> (active_ff && code_ff == CODE_STO && !motor_current_on);
   endproperty
   a_sto_raise: assert property (p_sto_raise) // R6
      else $error("safe-torque-off alarm not raised");

   property p_mech;
      @(posedge clk_sys) disable iff (!rstn)
      (!active_ff && home_is_set && mech_limit_reached && !f_gear &&
         !f_sto && !f_offset && !f_hw_ot && !f_sw_ot) |=>
         (active_ff && code_ff == CODE_MECH_OT);
   endproperty
   a_mech: assert property (p_mech) // R8
      else $error("mechanism limit alarm missing");
endmodule : motion_alarm_detector

// ---- core/motion_alarm_pkg.sv ----
// Behaviour
// R1: three-sensor homing, home sensor unseen between limits: 63h, clearable.
// R2: homing with no timing, zero or sensor_input_a signal seen raises 64h.
// R3: separate settings disable the timing/zero check and the sensor_input_a check.
// R4: limit action set to alarm stop; either limit input raises 66h.
// R5: software overtravel alarm mode; reaching software limit raises 67h.
// R6: safe-torque-off alarm mode; either input off raises 68h, current cut.
// R7: limit input seen during homing offset move raises 6Ah.
// R8: home set and mechanism limit reached raises 6Dh.
// R9: stored-data start with speed zero raises 70h, seven blinks.
// R10: wrap operation with wrap disabled raises 70h.
// R11: speed or current above protection limit raises 70h.
// R12: push-motion request on variant without push support raises 70h.
// R13: gear resolution out of range raises 71h, not clearable, current cut.
// R14: non-excitation alarms cut motor current.
// R15: excitation alarms keep motor current flowing.
// R16: latch active alarm code and blink its count until cleared.
package motion_alarm_pkg;
   // =========================================================
   // alarm codes
   localparam logic [7:0] CODE_NONE = 8'h00;
   localparam logic [7:0] CODE_NO_HOME = 8'h63;
   localparam logic [7:0] CODE_SIG = 8'h64;
   localparam logic [7:0] CODE_HW_OT = 8'h66;
   localparam logic [7:0] CODE_SW_OT = 8'h67;
   localparam logic [7:0] CODE_STO = 8'h68;
   localparam logic [7:0] CODE_OFFSET = 8'h6A;
   localparam logic [7:0] CODE_MECH_OT = 8'h6D;
   localparam logic [7:0] CODE_OPDATA = 8'h70;
   localparam logic [7:0] CODE_GEAR = 8'h71;
   // =========================================================
   // blink counts
   localparam logic [3:0] BLINK_ONE = 4'h1;
   localparam logic [3:0] BLINK_SEVEN = 4'h7;
   // =========================================================
   // indicator timing
   localparam int CLK_HZ = 10_000_000;
   localparam int BLINK_MS = 200;
   localparam int PAUSE_MS = 1000;
   localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
   localparam int PAUSE_CYC = CLK_HZ / 1000 * PAUSE_MS;
   // =========================================================
   // setting encodings
   localparam logic [1:0] LS_ACT_IMM_ALM = 2'h1;
   localparam logic [1:0] LS_ACT_DEC_ALM = 2'h2;
   localparam logic [1:0] SWOT_IMM_ALM = 2'h1;
   localparam logic [1:0] SWOT_DEC_ALM = 2'h2;
   localparam logic [7:0] SPEED_ZERO = 8'h00;
endpackage : motion_alarm_pkg

// ---- sim/sensor_far_side.sv ----
`timescale 1ns/100ps
// =========================================
// far-side sensors: pins follow the request one clock later
module sensor_far_side (
   // clock
   input wire logic clk_sys,
   // requested levels
   input wire logic [7:0] want,
   // sensor and safe-torque-off pins
   output logic home_sensor_input,
   output logic forward_limit_input,
   output logic reverse_limit_input,
   output logic step_timing_output,
   output logic encoder_zero_output,
   output logic sensor_input_a,
   output logic safe_torque_off_input_a,
   output logic safe_torque_off_input_b
);
   logic [7:0] pins_ff;
   always_ff @(posedge clk_sys) begin
      pins_ff <= want;
   end
   assign {safe_torque_off_input_b, safe_torque_off_input_a, sensor_input_a,
      encoder_zero_output, step_timing_output, reverse_limit_input,
      forward_limit_input, home_sensor_input} = pins_ff;
endmodule : sensor_far_side

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
   import motion_alarm_pkg::*;
   localparam int BLINK_TB = 4;
   localparam int PAUSE_TB = 10;
   // =========================================
   // stimulus, wiring and instances
   logic clk_sys = '0, rstn = '0, alarm_clear_input = '0;
   logic [7:0] want = 8'hC0;
   logic home_sensor_input, forward_limit_input, reverse_limit_input;
   logic step_timing_output, encoder_zero_output, sensor_input_a;
   logic safe_torque_off_input_a, safe_torque_off_input_b;
   logic homing_three_sensor = '0, homing_active = '0, homing_done = '0;
   logic homing_offset_move = '0, home_is_set = '0, gear_out_of_spec = '0;
   logic tim_zsg_check_en = '1, sensor_input_a_check_en = '1, sto_alarm_mode = '0;
   logic wrap_enabled = '1, push_supported = '1, op_start = '0;
   logic op_wrap = '0, op_push = '0;
   logic sw_limit_reached = '0, mech_limit_reached = '0;
   logic [1:0] limit_action = 2'h0, swot_action = 2'h0;
   logic [7:0] op_speed = 8'h10, op_current = 8'h10;
   logic [7:0] speed_limit = 8'h80, current_limit = 8'h80;
   logic alarm_active, motor_current_on, indicator_led;
   logic [7:0] alarm_code;
   logic [15:0] rnd = 16'h0006;
   int n_fail = 0, comparisons = 0, cycles = 0;

   motion_alarm_detector #(.BLINK_CYCLES(BLINK_TB), .PAUSE_CYCLES(PAUSE_TB))
      motion_alarm_detector_i (.*);
   sensor_far_side sensor_far_side_i (.*);

   always #50 clk_sys = ~clk_sys;

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [3:0] nb(input logic [7:0] c);
      return (c == CODE_STO) ? BLINK_ONE : BLINK_SEVEN;
   endfunction : nb
   function automatic logic exc(input logic [7:0] c);
      return !(c == CODE_STO || c == CODE_GEAR);
   endfunction : exc

   task automatic tally_and_finish;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic tk(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : tk
   task automatic chk(input string s, input logic [7:0] e, g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic quiet;
      want = 8'hC0;
      {limit_action, swot_action} = 4'h0;
      {sto_alarm_mode, sw_limit_reached, mech_limit_reached} = 3'h0;
      {homing_offset_move, home_is_set, homing_active} = 3'h0;
      {homing_three_sensor, gear_out_of_spec} = 2'h0;
      {tim_zsg_check_en, sensor_input_a_check_en} = 2'h3;
   endtask : quiet
   task automatic none;
      tk(3);
      chk("active", 8'h00, 8'(alarm_active));
      quiet();
      tk(2);
   endtask : none
   // latched state, current and one full blink period of the indicator
   task automatic alarm(input logic [7:0] c);
      int n;
      logic p;
      tk(3);
      chk("active", 8'h01, 8'(alarm_active));
      chk("code", c, alarm_code);
      chk("current", 8'(exc(c)), 8'(motor_current_on));
      n = 0;
      p = indicator_led;
      // exactly one period: the on/off pairs, the pause and a restart cycle
      repeat (2 * BLINK_TB * nb(c) + PAUSE_TB + 1) begin
         tk(1);
         if (indicator_led === 1'h1 && p !== 1'h1) n++;
         p = indicator_led;
      end
      chk("blinks", 8'(nb(c)), 8'(n));
   endtask : alarm
   task automatic clear;
      quiet();
      alarm_clear_input = '1;
      tk(2);
      alarm_clear_input = '0;
      tk(1);
      chk("code", CODE_NONE, alarm_code);
      chk("current", 8'h01, 8'(motor_current_on));
   endtask : clear

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 30000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   initial begin
      tk(20);
      rstn = '1;
      tk(1);
      chk("code", CODE_NONE, alarm_code);
      chk("current", 8'h01, 8'(motor_current_on));
      for (int i = 0; i < 4; i++) begin
         limit_action = i[0] ? LS_ACT_DEC_ALM : LS_ACT_IMM_ALM;
         want[i[1] + 1] = '1;
         alarm(CODE_HW_OT);
         clear();
         swot_action = i[0] ? SWOT_DEC_ALM : SWOT_IMM_ALM;
         sw_limit_reached = '1;
         alarm(CODE_SW_OT);
         clear();
         sto_alarm_mode = '1;
         want[6 + i[1]] = '0;
         alarm(CODE_STO);
         clear();
         homing_offset_move = '1;
         want[i[1] + 1] = '1;
         alarm(CODE_OFFSET);
         clear();
      end
      for (int a = 0; a < 4; a += 3) begin
         {limit_action, swot_action} = {2'(a), 2'(a)};
         want = 8'h82;
         {sw_limit_reached, mech_limit_reached} = 2'h3;
         none();
      end
      home_is_set = '1;
      mech_limit_reached = '1;
      alarm(CODE_MECH_OT);
      clear();
      for (int k = 0; k < 9; k++) begin
         rnd = lfsr(rnd);
         op_speed = (k == 0) ? 8'h00 :
            (k == 2) ? 8'h81 + {2'h0, rnd[5:0]} :
            (k == 5) ? speed_limit : 8'h01 + {1'h0, rnd[6:0]};
         op_current = (k == 3) ? 8'h81 + {2'h0, rnd[13:8]} :
            (k == 5) ? current_limit : 8'h01 + {1'h0, rnd[14:8]};
         op_wrap = rnd[15] | (k == 1);
         op_push = rnd[7] | (k == 4);
         wrap_enabled = k != 1;
         push_supported = k != 4;
         op_start = '1;
         tk(1);
         op_start = '0;
         if (k < 5) alarm(CODE_OPDATA);
         else none();
         if (k < 5) clear();
      end
      for (int k = 0; k < 7; k++) begin
         {tim_zsg_check_en, sensor_input_a_check_en} = (k < 4) ? 2'(k) : 2'h3;
         homing_active = '1;
         tk(2);
         if (k > 3) want[k - 1] = '1;
         tk(3);
         want[5:3] = 3'h0;
         tk(2);
         homing_done = '1;
         tk(1);
         homing_done = '0;
         if (k == 0 || k > 3) none();
         else begin
            alarm(CODE_SIG);
            clear();
         end
      end
      for (int k = 0; k < 2; k++) begin
         {homing_three_sensor, homing_active} = 2'h3;
         want[0] = k[0];
         tk(3);
         want[0] = '0;
         tk(2);
         want[2] = '1;
         if (k == 1) none();
         else begin
            alarm(CODE_NO_HOME);
            clear();
         end
      end
      gear_out_of_spec = '1;
      alarm(CODE_GEAR);
      quiet();
      alarm_clear_input = '1;
      tk(2);
      alarm_clear_input = '0;
      limit_action = LS_ACT_IMM_ALM;
      want[1] = '1;
      tk(3);
      chk("code", CODE_GEAR, alarm_code);
      rstn = '0;
      quiet();
      tk(2);
      rstn = '1;
      tk(1);
      chk("code", CODE_NONE, alarm_code);
      tally_and_finish();
   end
endmodule : tb_top
